// ### pkg/drg_regs.svh
// Offsets, field positions and reset values of the shared control registers.
// Included by the package users; holds definitions only.
`ifndef DRG_REGS_SVH
`define DRG_REGS_SVH

`define DRG_OFS_ADDR 8'h00
`define DRG_OFS_RST 8'h01
`define DRG_OFS_GCFG 8'h02
`define DRG_OFS_STS 8'h04

`define DRG_BIT_ADDR_SRC 0
`define DRG_ADDR_HI 7
`define DRG_ADDR_LO 1

`define DRG_BIT_RELOAD 2
`define DRG_BIT_RST_FULL 1
`define DRG_BIT_RST_KEEP 0
`define DRG_RST_RSVD_HI 7
`define DRG_RST_RSVD_LO 3

`define DRG_BIT_PORT_OVR 7
`define DRG_BIT_PORT_SEL 6
`define DRG_BIT_OUT_OVR 5
`define DRG_BIT_GCFG_RSVD 4
`define DRG_BIT_OUT_GATE 3
`define DRG_BIT_IDLE_SEL 2

`define DRG_BIT_INIT_DONE 6

`define DRG_RST_ADDR 7'h3D
`define DRG_RST_RSVD 5'h00
`define DRG_RST_PORT_OVR 1'h0
`define DRG_RST_PORT_SEL 1'h0
`define DRG_RST_OUT_OVR 1'h0
`define DRG_RST_GCFG_RSVD 1'h1
`define DRG_RST_OUT_GATE 1'h1
`define DRG_RST_IDLE_SEL 1'h1

`define DRG_LAST_BIT 3'h7

`endif

// ### pkg/drg_pkg.sv
// Types shared by the control register block and its serial bus slave.
// No assumptions beyond a SystemVerilog-2012 compiler.
package drg_pkg;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } drg_req_s;

  typedef struct packed {
    logic port_sel;
    logic hiz;
    logic low_idle;
  } drg_out_s;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ACK_A = 3'b010,
    I2C_WRITE = 3'b011,
    I2C_ACK_W = 3'b100,
    I2C_READ = 3'b101,
    I2C_ACK_R = 3'b110
  } drg_i2c_e;

  typedef enum logic [1:0] {
    LD_START = 2'b00,
    LD_WAIT = 2'b01,
    LD_DONE = 2'b10
  } drg_ld_e;

endpackage : drg_pkg

// ### hdl/drg_i2c_slave.sv
// Two-wire serial slave: pointer byte then auto-incrementing data bytes.
// Assumes SCL and SDA already synchronous to clk; open-drain SDA low-drive only.
`timescale 1ns/1ns
`include "drg_regs.svh"
module drg_i2c_slave import drg_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic soft_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [6:0] own_addr,
  input wire logic [7:0] rdata,
  output drg_req_s req,
  output logic [7:0] rd_addr,
  output logic busy,
  output logic sda_oe_n
);
  drg_i2c_e st_r;
  logic scl_q, sda_q, got8_r, first_r, rw_r, drive_r, wr_r;
  logic [2:0] cnt_r;
  logic [7:0] sh_r, ptr_r, wadr_r, wdata_r;

  wire start_c = scl_i & scl_q & sda_q & ~sda_i;
  wire stop_c = scl_i & scl_q & ~sda_q & sda_i;
  wire rise_c = scl_i & ~scl_q;
  wire fall_c = ~scl_i & scl_q;
  wire last_c = (cnt_r == `DRG_LAST_BIT);

  assign req = '{wr: wr_r, addr: wadr_r, wdata: wdata_r};
  assign rd_addr = ptr_r;
  assign busy = (st_r != I2C_IDLE);
  assign sda_oe_n = ~drive_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= I2C_IDLE;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      got8_r <= 1'h0;
      first_r <= 1'h0;
      rw_r <= 1'h0;
      drive_r <= 1'h0;
      wr_r <= 1'h0;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      wadr_r <= 8'h00;
      wdata_r <= 8'h00;
    end else if (ce) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_r <= 1'h0;
      if (soft_rst) begin
        st_r <= I2C_IDLE;
        drive_r <= 1'h0;
        got8_r <= 1'h0;
      end else if (start_c) begin
        st_r <= I2C_ADDR;
        cnt_r <= 3'h0;
        got8_r <= 1'h0;
        drive_r <= 1'h0;
        first_r <= 1'h1;
      end else if (stop_c) begin
        st_r <= I2C_IDLE;
        drive_r <= 1'h0;
      end else begin
        case (st_r)
          I2C_ADDR, I2C_WRITE: begin
            if (rise_c) begin
              sh_r <= {sh_r[6:0], sda_i};
              cnt_r <= 3'(cnt_r + 3'h1);
              got8_r <= last_c;
            end else if (fall_c && got8_r) begin
              got8_r <= 1'h0;
              if (st_r == I2C_ADDR) begin
                // Other addresses: stay off the bus until the next start
                if (sh_r[7:1] == own_addr) begin
                  drive_r <= 1'h1;
                  rw_r <= sh_r[0];
                  st_r <= I2C_ACK_A;
                end else begin
                  st_r <= I2C_IDLE;
                end
              end else begin
                drive_r <= 1'h1;
                st_r <= I2C_ACK_W;
                if (first_r) begin
                  ptr_r <= sh_r;
                  first_r <= 1'h0;
                end else begin
                  wr_r <= 1'h1;
                  wadr_r <= ptr_r;
                  wdata_r <= sh_r;
                  ptr_r <= 8'(ptr_r + 8'h01);
                end
              end
            end
          end
          I2C_ACK_A: begin
            if (fall_c) begin
              cnt_r <= 3'h0;
              if (rw_r) begin
                st_r <= I2C_READ;
                sh_r <= rdata;
                drive_r <= ~rdata[7];
              end else begin
                st_r <= I2C_WRITE;
                drive_r <= 1'h0;
              end
            end
          end
          I2C_ACK_W: begin
            if (fall_c) begin
              drive_r <= 1'h0;
              st_r <= I2C_WRITE;
            end
          end
          I2C_READ: begin
            if (rise_c) begin
              cnt_r <= 3'(cnt_r + 3'h1);
              got8_r <= last_c;
            end else if (fall_c) begin
              if (got8_r) begin
                got8_r <= 1'h0;
                drive_r <= 1'h0;
                st_r <= I2C_ACK_R;
                ptr_r <= 8'(ptr_r + 8'h01);
              end else begin
                sh_r <= {sh_r[6:0], 1'h0};
                drive_r <= ~sh_r[6];
              end
            end
          end
          I2C_ACK_R: begin
            // Master NACK ends the read; a repeated start is still seen
            if (rise_c) begin
              if (sda_i) begin
                st_r <= I2C_IDLE;
              end else begin
                got8_r <= 1'h1;
              end
            end else if (fall_c && got8_r) begin
              got8_r <= 1'h0;
              st_r <= I2C_READ;
              sh_r <= rdata;
              drive_r <= ~rdata[7];
            end
          end
          default: begin
            st_r <= I2C_IDLE;
          end
        endcase
      end
    end
  end

endmodule : drg_i2c_slave

// ### hdl/drg_top.sv
// Shared control registers: own bus address, reset control, general config.
// Assumes pins synchronous to REF_CLK and a ROM loader that pulses done.
// Notes on behaviour
// - Address field always shows active bus address
// - Source bit picks strap or written address
// - Reload bit restarts ROM load, self-clears
// - Init-done status shows reload completion
// - Full reset clears logic and registers
// - Partial reset clears logic, keeps registers
// - Port override picks register select bit
// - Select bit drives mode or shows pin
// - Output override takes gate, idle from registers
// - Idle one, gate zero: outputs high impedance
// - Unlocked with idle zero: outputs driven low
// - Without override, bits mirror the pins
// - Init-done set after power-up ROM load
`timescale 1ns/1ns
`include "drg_regs.svh"
module drg_top import drg_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  input wire logic [6:0] ADDRESS_STRAP_PIN,
  input wire logic PORT_SEL_PIN,
  input wire logic PIN_OUTPUT_GATE,
  input wire logic IDLE_STATE_PIN,
  input wire logic LINK_LOCKED,
  input wire logic ROM_LOAD_DONE,
  output logic ROM_LOAD_START,
  output drg_out_s OUT_CTRL
);
  drg_req_s req;
  logic [7:0] rd_addr, rd_data;
  logic i2c_busy;
  logic src_r, port_ovr_r, port_sel_r, out_ovr_r, gcfg_rsv_r, oe_r, oss_r;
  logic [6:0] addr_r;
  logic [4:0] rsv_rst_r;
  logic pend_reload_r, pend_full_r, pend_keep_r, srst_full_r, srst_keep_r;
  logic init_done_r;
  drg_ld_e ld_state_r, ld_nxt;
  drg_out_s out_r, out_nxt;

  wire [7:0] wd = req.wdata;
  wire wr_addr = req.wr && (req.addr == `DRG_OFS_ADDR);
  wire wr_rst = req.wr && (req.addr == `DRG_OFS_RST);
  wire wr_gcfg = req.wr && (req.addr == `DRG_OFS_GCFG);
  wire reg_clr = srst_full_r;
  wire logic_rst = srst_full_r | srst_keep_r;

  wire [6:0] act_addr = src_r ? addr_r : ADDRESS_STRAP_PIN;
  wire port_sel_eff = port_ovr_r ? port_sel_r : PORT_SEL_PIN;
  wire oe_eff = out_ovr_r ? oe_r : PIN_OUTPUT_GATE;
  wire oss_eff = out_ovr_r ? oss_r : IDLE_STATE_PIN;

  // Readback fields in bit order, high to low
  wire [7:0] rd_addr_reg = {act_addr, src_r};
  wire [7:0] rd_rst_reg = {rsv_rst_r, pend_reload_r, pend_full_r, pend_keep_r};
  wire [7:0] rd_gcfg_reg = {port_ovr_r, port_sel_eff, out_ovr_r, gcfg_rsv_r,
                            oe_eff, oss_eff, 2'h0};
  wire [7:0] rd_sts_reg = 8'(init_done_r) << `DRG_BIT_INIT_DONE;

  assign rd_data = (rd_addr == `DRG_OFS_ADDR) ? rd_addr_reg :
                   (rd_addr == `DRG_OFS_RST) ? rd_rst_reg :
                   (rd_addr == `DRG_OFS_GCFG) ? rd_gcfg_reg :
                   (rd_addr == `DRG_OFS_STS) ? rd_sts_reg : 8'h00;

  assign SDA_O = 1'h0;
  assign ROM_LOAD_START = (ld_state_r == LD_START);
  assign OUT_CTRL = out_r;

  // Engine resets with the digital logic; its compare picks up a new address next frame
  drg_i2c_slave u_slave (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .ce(CLK_EN),
    .soft_rst(logic_rst),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .own_addr(act_addr),
    .rdata(rd_data),
    .req(req),
    .rd_addr(rd_addr),
    .busy(i2c_busy),
    .sda_oe_n(SDA_OE_N)
  );

  // Register file
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      src_r <= 1'h0;
      addr_r <= `DRG_RST_ADDR;
      rsv_rst_r <= `DRG_RST_RSVD;
      port_ovr_r <= `DRG_RST_PORT_OVR;
      port_sel_r <= `DRG_RST_PORT_SEL;
      out_ovr_r <= `DRG_RST_OUT_OVR;
      gcfg_rsv_r <= `DRG_RST_GCFG_RSVD;
      oe_r <= `DRG_RST_OUT_GATE;
      oss_r <= `DRG_RST_IDLE_SEL;
    end else if (CLK_EN) begin
      if (reg_clr) begin
        src_r <= 1'h0;
        addr_r <= `DRG_RST_ADDR;
        rsv_rst_r <= `DRG_RST_RSVD;
        port_ovr_r <= `DRG_RST_PORT_OVR;
        port_sel_r <= `DRG_RST_PORT_SEL;
        out_ovr_r <= `DRG_RST_OUT_OVR;
        gcfg_rsv_r <= `DRG_RST_GCFG_RSVD;
        oe_r <= `DRG_RST_OUT_GATE;
        oss_r <= `DRG_RST_IDLE_SEL;
      end else begin
        if (wr_addr) begin
          src_r <= wd[`DRG_BIT_ADDR_SRC];
        end
        // Tracking the strap while the source bit is clear; turning override on loads the written address
        if (wr_addr && wd[`DRG_BIT_ADDR_SRC]) begin
          addr_r <= wd[`DRG_ADDR_HI:`DRG_ADDR_LO];
        end else if (!src_r) begin
          addr_r <= ADDRESS_STRAP_PIN;
        end
        if (wr_rst) begin
          rsv_rst_r <= wd[`DRG_RST_RSVD_HI:`DRG_RST_RSVD_LO];
        end
        if (wr_gcfg) begin
          port_ovr_r <= wd[`DRG_BIT_PORT_OVR];
          port_sel_r <= wd[`DRG_BIT_PORT_SEL];
          out_ovr_r <= wd[`DRG_BIT_OUT_OVR];
          gcfg_rsv_r <= wd[`DRG_BIT_GCFG_RSVD];
          oe_r <= wd[`DRG_BIT_OUT_GATE];
          oss_r <= wd[`DRG_BIT_IDLE_SEL];
        end
      end
    end
  end

  // Resets wait for an idle bus so the pending acknowledge is not cut short
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pend_full_r <= 1'h0;
      pend_keep_r <= 1'h0;
      pend_reload_r <= 1'h0;
      srst_full_r <= 1'h0;
      srst_keep_r <= 1'h0;
    end else if (CLK_EN) begin
      pend_full_r <= (wr_rst & wd[`DRG_BIT_RST_FULL]) | (pend_full_r & i2c_busy);
      pend_keep_r <= (wr_rst & wd[`DRG_BIT_RST_KEEP]) | (pend_keep_r & i2c_busy);
      srst_full_r <= pend_full_r & ~i2c_busy;
      srst_keep_r <= pend_keep_r & ~i2c_busy;
      pend_reload_r <= (wr_rst & wd[`DRG_BIT_RELOAD]) |
                       (pend_reload_r & (ld_state_r != LD_DONE));
    end
  end

  // ROM loader sequencing; both digital resets rerun the power-up load
  always_comb begin
    ld_nxt = ld_state_r;
    case (ld_state_r)
      LD_START: ld_nxt = LD_WAIT;
      LD_WAIT: ld_nxt = ROM_LOAD_DONE ? LD_DONE : LD_WAIT;
      LD_DONE: ld_nxt = pend_reload_r ? LD_START : LD_DONE;
      default: ld_nxt = LD_START;
    endcase
    if (logic_rst) begin
      ld_nxt = LD_START;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ld_state_r <= LD_START;
      init_done_r <= 1'h0;
    end else if (CLK_EN) begin
      ld_state_r <= ld_nxt;
      if (ld_state_r == LD_START) begin
        init_done_r <= 1'h0;
      end else if (ld_state_r == LD_WAIT && ROM_LOAD_DONE) begin
        init_done_r <= 1'h1;
      end
    end
  end

  // Parallel output control; other combinations leave the outputs driving data
  always_comb begin
    out_nxt.port_sel = port_sel_eff;
    out_nxt.hiz = oss_eff & ~oe_eff;
    out_nxt.low_idle = ~oss_eff & ~LINK_LOCKED;
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      out_r <= '{port_sel: 1'h0, hiz: 1'h0, low_idle: 1'h0};
    end else if (CLK_EN) begin
      out_r <= out_nxt;
    end
  end

  sequence s_load_start;
    ld_state_r == LD_START && CLK_EN && !logic_rst;
  endsequence

  sequence s_load_wait;
    ld_state_r == LD_WAIT && !init_done_r;
  endsequence

  a_strap_addr: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && !src_r && !wr_addr && !reg_clr |=> addr_r == $past(ADDRESS_STRAP_PIN))
    else $error("address field does not follow the strap");

  a_addr_override: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && wr_addr && wd[`DRG_BIT_ADDR_SRC] && !reg_clr
    |=> src_r && rd_addr_reg[`DRG_ADDR_HI:`DRG_ADDR_LO] == $past(wd[`DRG_ADDR_HI:`DRG_ADDR_LO]))
    else $error("written address not in use");

  a_reload_start: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && pend_reload_r && ld_state_r == LD_DONE && !logic_rst && !wr_rst
    |=> ld_state_r == LD_START && !pend_reload_r)
    else $error("reload trigger not taken");

  a_load_clears_done: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    s_load_start |=> s_load_wait)
    else $error("init done not cleared at load start");

  a_done_sets: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && ld_state_r == LD_WAIT && ROM_LOAD_DONE && !logic_rst
    |=> init_done_r && ld_state_r == LD_DONE && rd_sts_reg[`DRG_BIT_INIT_DONE])
    else $error("init done not set after load");

  a_full_reset: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && srst_full_r |=> !src_r && !port_ovr_r && !out_ovr_r && oe_r && oss_r
    && ld_state_r == LD_START && !srst_full_r)
    else $error("full reset left state behind");

  a_keep_regs: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && srst_keep_r && !srst_full_r && !req.wr
    |=> $stable(port_ovr_r) && $stable(oe_r) && $stable(src_r) && ld_state_r == LD_START)
    else $error("partial reset disturbed registers");

  a_port_select: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN |=> OUT_CTRL.port_sel == $past(port_sel_eff))
    else $error("port select output wrong");

  a_hiz_out: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && out_ovr_r && oss_r && !oe_r |=> OUT_CTRL.hiz)
    else $error("outputs not high impedance");

  a_low_idle: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && !oss_eff && !LINK_LOCKED |=> OUT_CTRL.low_idle && !OUT_CTRL.hiz)
    else $error("outputs not forced low while unlocked");

  a_pin_mirror: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !out_ovr_r |-> rd_gcfg_reg[`DRG_BIT_OUT_GATE] == PIN_OUTPUT_GATE
    && rd_gcfg_reg[`DRG_BIT_IDLE_SEL] == IDLE_STATE_PIN)
    else $error("output bits do not mirror pins");

  a_zero_write: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && wr_rst && !wd[`DRG_BIT_RST_FULL] && !pend_full_r |=> !pend_full_r && !srst_full_r)
    else $error("writing zero started a reset");

endmodule : drg_top

// ### test/drg_host.sv
// Host model for the two-wire control bus: master side, open-drain SDA.
// Assumes the bench ANDs sda_rel with the device drive to form the pulled-up line.
`timescale 1ns/1ns
module drg_host (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_rel,
  output logic [7:0] rd_byte,
  output logic rd_stb
);
  // Phase length in cycles; the bench raises it to act as a slow host
  int half = 3;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    rd_byte = 8'h00;
    rd_stb = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc
  task automatic post(input logic [7:0] v);
    rd_byte = v;
    rd_stb = 1'b1;
    wait_cyc(1);
    rd_stb = 1'b0;
  endtask : post
  // Also serves as repeated start from a low clock
  task automatic start_c();
    wait_cyc(1);
    sda_rel = 1'b1;
    wait_cyc(half);
    scl = 1'b1;
    wait_cyc(half);
    sda_rel = 1'b0;
    wait_cyc(half);
    scl = 1'b0;
  endtask : start_c
  // Data moves one cycle after the fall, never with clock high
  task automatic bit_c(input logic b, output logic s);
    wait_cyc(1);
    sda_rel = b;
    wait_cyc(half);
    scl = 1'b1;
    wait_cyc(half);
    s = sda_in;
    wait_cyc(half);
    scl = 1'b0;
  endtask : bit_c
  task automatic byte_c(input logic [7:0] tx, input logic ack_m, output logic [7:0] rx,
      output logic ack_s);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(tx[i], s);
      rx[i] = s;
    end
    bit_c(ack_m, s);
    ack_s = !s;
  endtask : byte_c
  task automatic stop_c();
    wait_cyc(1);
    sda_rel = 1'b0;
    wait_cyc(half);
    scl = 1'b1;
    wait_cyc(half);
    sda_rel = 1'b1;
    wait_cyc(4 * half);
  endtask : stop_c
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] rx;
    logic a;
    start_c();
    byte_c({dev, 1'b0}, 1'b1, rx, a);
    byte_c(ptr, 1'b1, rx, a);
    byte_c(d, 1'b1, rx, a);
    stop_c();
  endtask : write_reg
  // Single byte read, ended by a host NACK
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr);
    logic [7:0] rx;
    logic a;
    start_c();
    byte_c({dev, 1'b0}, 1'b1, rx, a);
    byte_c(ptr, 1'b1, rx, a);
    start_c();
    byte_c({dev, 1'b1}, 1'b1, rx, a);
    byte_c(8'hFF, 1'b1, rx, a);
    stop_c();
    post(rx);
  endtask : read_reg
  task automatic probe(input logic [6:0] dev);
    logic [7:0] rx;
    logic a;
    start_c();
    byte_c({dev, 1'b0}, 1'b1, rx, a);
    stop_c();
    post({7'h00, a});
  endtask : probe
endmodule : drg_host

// ### test/tb.sv
// Self-checking bench for the shared control registers over the two-wire bus.
// Assumes pins driven at falling edges; results checked from a queue of notes.
`timescale 1ns/1ns
module tb import drg_pkg::*;;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] strap = 7'h3D;
  logic port_pin = 1'b0, gate_pin = 1'b1, idle_pin = 1'b1, locked = 1'b0, rom_done = 1'b0;
  logic rom_start, sda_o, sda_oe_n, scl, sda_rel, rd_stb, rs_d = 1'b0, samp_stb = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] rd_byte;
  logic [7:0] samp_val = 8'h00;
  drg_out_s out_ctrl;
  // Open drain: the device's drive level only counts while its enable is active
  wire sda_line = sda_rel & (sda_oe_n | sda_o);
  logic [7:0] exp_q[$];
  int errors = 0;
  int num_checks = 0;
  int seed = 73805;
  int loads = 0;
  always #5 ref_clk = ~ref_clk;
  drg_top i_dut (.REF_CLK(ref_clk), .RESETN(resetn), .CLK_EN(clk_en), .SCL_I(scl),
    .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .ADDRESS_STRAP_PIN(strap),
    .PORT_SEL_PIN(port_pin), .PIN_OUTPUT_GATE(gate_pin), .IDLE_STATE_PIN(idle_pin),
    .LINK_LOCKED(locked), .ROM_LOAD_DONE(rom_done), .ROM_LOAD_START(rom_start),
    .OUT_CTRL(out_ctrl));
  drg_host i_host (.clk(ref_clk), .sda_in(sda_line), .scl(scl), .sda_rel(sda_rel),
    .rd_byte(rd_byte), .rd_stb(rd_stb));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic final_report();
    // A note still queued means an expected result never showed up
    if (exp_q.size() != 0) begin
      errors++;
      $display("wrong value at %0t: %0d expected results never seen", $time, exp_q.size());
    end
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // Load requests after power-up are one-cycle pulses that can end inside a bus stop
  always @(posedge ref_clk) begin
    rs_d <= rom_start;
    if (rom_start === 1'b1 && rs_d !== 1'b1) loads++;
  end
  always @(posedge ref_clk) begin
    if (rd_stb === 1'b1) check(rd_byte, exp_q.pop_front());
    if (samp_stb === 1'b1) check(samp_val, exp_q.pop_front());
  end
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] want);
    exp_q.push_back(want);
    i_host.read_reg(dev, ptr);
  endtask : rd
  task automatic probe(input logic [6:0] dev, input logic [7:0] want);
    exp_q.push_back(want);
    i_host.probe(dev);
  endtask : probe
  task automatic obs(input logic [7:0] seen, input logic [7:0] want);
    exp_q.push_back(want);
    samp_val = seen;
    samp_stb = 1'b1;
    @(negedge ref_clk);
    samp_stb = 1'b0;
    @(negedge ref_clk);
  endtask : obs
  // Tests need about 15,000 cycles; the limit leaves more than twice that
  initial begin
    #500000;
    errors++;
    $display("wrong value at %0t: run timed out", $time);
    final_report();
  end
  initial begin
    logic [7:0] cfg;
    logic [6:0] nad;
    logic sel, gt, il;
    int base;
    strap = {2'b01, 5'($random(seed))};
    nad = strap ^ 7'h0C;
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(strap, 8'h00, {strap, 1'b0});
    rd(strap, 8'h01, 8'h00);
    rd(strap, 8'h04, 8'h00);
    rom_done = 1'b1;
    rd(strap, 8'h04, 8'h40);
    rd(strap, 8'h03, 8'h00);
    $display("test defaults done");
    i_host.write_reg(strap, 8'h00, {nad, 1'b0});
    rd(strap, 8'h00, {strap, 1'b0});
    i_host.write_reg(strap, 8'h00, {nad, 1'b1});
    probe(strap, 8'h00);
    i_host.half = 6;
    rd(nad, 8'h00, {nad, 1'b1});
    i_host.write_reg(nad, 8'h00, 8'h00);
    i_host.half = 2;
    rd(strap, 8'h00, {strap, 1'b0});
    $display("test address done");
    for (int i = 0; i < 12; i++) begin
      // First pass forces the high impedance combination
      cfg = (i == 0) ? 8'hE4 : 8'($random(seed));
      {port_pin, gate_pin, idle_pin, locked} = 4'($random(seed));
      i_host.write_reg(strap, 8'h02, cfg);
      sel = cfg[7] ? cfg[6] : port_pin;
      gt = cfg[5] ? cfg[3] : gate_pin;
      il = cfg[5] ? cfg[2] : idle_pin;
      obs({5'h00, out_ctrl}, {5'h00, sel, il & !gt, !il & !locked});
      rd(strap, 8'h02, {cfg[7], sel, cfg[5], cfg[4], gt, il, 2'b00});
    end
    $display("test config done");
    locked = 1'b0;
    i_host.write_reg(strap, 8'h02, 8'hE8);
    obs({5'h00, out_ctrl}, 8'h05);
    i_host.write_reg(strap, 8'h00, {nad, 1'b1});
    rom_done = 1'b0;
    base = loads;
    i_host.write_reg(nad, 8'h01, 8'hF9);
    rd(nad, 8'h04, 8'h00);
    rd(nad, 8'h01, 8'hF8);
    rd(nad, 8'h02, 8'hE8);
    obs(8'(loads - base), 8'h01);
    rom_done = 1'b1;
    rd(nad, 8'h04, 8'h40);
    rom_done = 1'b0;
    base = loads;
    i_host.write_reg(nad, 8'h01, 8'hFC);
    rd(nad, 8'h01, 8'hF8);
    obs(8'(loads - base), 8'h01);
    rd(nad, 8'h04, 8'h00);
    rom_done = 1'b1;
    rd(nad, 8'h04, 8'h40);
    $display("test partial reset and reload done");
    i_host.write_reg(nad, 8'h01, 8'h02);
    rd(strap, 8'h00, {strap, 1'b0});
    rd(strap, 8'h02, {1'b0, port_pin, 2'b01, gate_pin, idle_pin, 2'b00});
    rd(strap, 8'h01, 8'h00);
    $display("test full reset done");
    // Frozen state must ignore the pin until the enable returns
    clk_en = 1'b0;
    port_pin = !port_pin;
    repeat (3) @(negedge ref_clk);
    obs({7'h00, out_ctrl.port_sel}, {7'h00, !port_pin});
    clk_en = 1'b1;
    repeat (2) @(negedge ref_clk);
    obs({7'h00, out_ctrl.port_sel}, {7'h00, port_pin});
    $display("test clock enable done");
    final_report();
  end
endmodule : tb
